// [timer_event_status_compare.sv]
// Event status, interrupt enables, upper capture and eight compare channels of a timer.
// Assumes counters, period and capture logic outside give synchronous one-cycle pulses.
`timescale 1ns/1ns
module timer_event_status_compare (
    input wire logic pclk, // Clock, 10 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic [31:0] lower_counter_half, // Lower counter value
    input wire logic unchained_mode, // Timer in 32-bit unchained mode
    input wire logic lower_timer_enable, // Lower half counting
    input wire logic upper_timer_enable, // Upper half counting
    input wire logic lower_period_match, // Lower counter equals period
    input wire logic upper_period_match, // Upper counter equals period
    input wire logic lower_capture_event, // Lower capture-mode event
    input wire logic upper_capture_event, // Upper capture-mode event
    input wire logic upper_capture_strobe, // Load upper capture word
    input wire logic [31:0] upper_capture_data, // Upper counter to capture
    output logic lower_irq, // Lower half interrupt
    output logic upper_irq, // Upper half interrupt
    output logic compare_irq, // Any unmasked compare flag
    output logic [timer_event_pkg::NUM_CMP-1:0] compare_dma_event, // Per-channel DMA pulse
    output logic irq // Combined interrupt
);
    import timer_event_pkg::*;

    logic [31:0] upper_capture_value;
    logic [31:0] compare_value [NUM_CMP];
    logic [NUM_CMP-1:0] cmp_mask;
    logic compare_feature_enable;
    logic lower_period_irq_enable;
    logic lower_event_irq_enable;
    logic upper_period_irq_enable;
    logic upper_event_irq_enable;
    logic [3:0] ics_flags;
    logic [3:0] ics_set;
    logic [3:0] ics_clr;
    logic [NUM_CMP-1:0] cmp_flags;
    logic [NUM_CMP-1:0] cmp_hit;
    logic [NUM_CMP-1:0] cmp_clr;
    logic lower_period_flag;
    logic lower_event_flag;
    logic upper_period_flag;
    logic upper_event_flag;
    logic cmp_active;
    logic access;
    logic wr_en;
    logic rd_hit;
    logic cmp_sel;
    logic [2:0] cmp_idx;
    logic [31:0] rd_word;
    logic [31:0] ics_word;

    // Flag order in the bank: lower period, lower event, upper period, upper event
    assign lower_period_flag = ics_flags[0];
    assign lower_event_flag = ics_flags[1];
    assign upper_period_flag = ics_flags[2];
    assign upper_event_flag = ics_flags[3];

    // APB decode; one wait state before each answer
    assign access = psel && penable && !pready;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign cmp_sel = (paddr >= OFS_CMP_BASE) && (paddr <= OFS_CMP_LAST) && (paddr[1:0] == 2'b00);
    assign cmp_idx = paddr[4:2];
    assign cmp_active = compare_feature_enable && unchained_mode;

    // Read image of the control and status word; reserved bits stay zero
    always_comb begin
        ics_word = RST_WORD;
        ics_word[BIT_LOWER_PERIOD_EN] = lower_period_irq_enable;
        ics_word[BIT_LOWER_PERIOD_FLAG] = lower_period_flag;
        ics_word[BIT_LOWER_EVENT_EN] = lower_event_irq_enable;
        ics_word[BIT_LOWER_EVENT_FLAG] = lower_event_flag;
        ics_word[BIT_UPPER_PERIOD_EN] = upper_period_irq_enable;
        ics_word[BIT_UPPER_PERIOD_FLAG] = upper_period_flag;
        ics_word[BIT_UPPER_EVENT_EN] = upper_event_irq_enable;
        ics_word[BIT_UPPER_EVENT_FLAG] = upper_event_flag;
    end

    // Read mux and address check
    always_comb begin
        rd_word = RST_WORD;
        rd_hit = 1'b1;
        if (cmp_sel) begin
            rd_word = compare_value[cmp_idx];
        end else begin
            unique case (paddr)
                OFS_UPPER_CAPTURE: rd_word = upper_capture_value;
                OFS_INT_CTRL_STAT: rd_word = ics_word;
                OFS_CMP_CTRL: rd_word[BIT_CMP_FEATURE_EN] = compare_feature_enable;
                OFS_CMP_STATUS: rd_word[NUM_CMP-1:0] = cmp_flags;
                OFS_CMP_MASK: rd_word[NUM_CMP-1:0] = cmp_mask;
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= RST_WORD;
            pslverr <= 1'b0;
        end else begin
            pready <= access;
            pslverr <= access && !rd_hit;
            if (access && !pwrite) begin
                prdata <= rd_word;
            end
        end
    end

    // Upper capture word; a hardware capture beats a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_capture_value <= RST_WORD;
        end else if (upper_capture_strobe) begin
            upper_capture_value <= upper_capture_data;
        end else if (wr_en && paddr == OFS_UPPER_CAPTURE) begin
            upper_capture_value <= pwdata;
        end
    end

    // Interrupt enable bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lower_period_irq_enable <= 1'b0;
            lower_event_irq_enable <= 1'b0;
            upper_period_irq_enable <= 1'b0;
            upper_event_irq_enable <= 1'b0;
        end else if (wr_en && paddr == OFS_INT_CTRL_STAT) begin
            lower_period_irq_enable <= pwdata[BIT_LOWER_PERIOD_EN];
            lower_event_irq_enable <= pwdata[BIT_LOWER_EVENT_EN];
            upper_period_irq_enable <= pwdata[BIT_UPPER_PERIOD_EN];
            upper_event_irq_enable <= pwdata[BIT_UPPER_EVENT_EN];
        end
    end

    // Hardware sets and write-one clears of the half flags
    always_comb begin
        ics_set[0] = lower_period_match && lower_timer_enable;
        ics_set[1] = lower_capture_event;
        ics_set[2] = upper_period_match && upper_timer_enable;
        ics_set[3] = upper_capture_event;
        ics_clr = 4'h0;
        if (wr_en && paddr == OFS_INT_CTRL_STAT) begin
            ics_clr[0] = pwdata[BIT_LOWER_PERIOD_FLAG];
            ics_clr[1] = pwdata[BIT_LOWER_EVENT_FLAG];
            ics_clr[2] = pwdata[BIT_UPPER_PERIOD_FLAG];
            ics_clr[3] = pwdata[BIT_UPPER_EVENT_FLAG];
        end
    end

    event_flag_bank #(.W(4)) u_half_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set(ics_set),
        .clr(ics_clr),
        .q(ics_flags)
    );

    // Compare control, mask and compare values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_feature_enable <= 1'b0;
            cmp_mask <= '0;
        end else if (wr_en) begin
            if (paddr == OFS_CMP_CTRL) begin
                compare_feature_enable <= pwdata[BIT_CMP_FEATURE_EN];
            end
            if (paddr == OFS_CMP_MASK) begin
                cmp_mask <= pwdata[NUM_CMP-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_CMP; i++) begin
                compare_value[i] <= RST_WORD;
            end
        end else if (wr_en && cmp_sel) begin
            compare_value[cmp_idx] <= pwdata;
        end
    end

    // Eight channels only watch the counter; nothing is fed back to it
    for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp
        compare_channel u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .active(cmp_active),
            .count(lower_counter_half),
            .value(compare_value[g]),
            .hit(cmp_hit[g])
        );
    end

    assign cmp_clr = (wr_en && paddr == OFS_CMP_STATUS) ? pwdata[NUM_CMP-1:0] : '0;

    event_flag_bank #(.W(NUM_CMP)) u_cmp_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set(cmp_hit),
        .clr(cmp_clr),
        .q(cmp_flags)
    );

    // Registered interrupt and DMA outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lower_irq <= 1'b0;
            upper_irq <= 1'b0;
            compare_irq <= 1'b0;
            compare_dma_event <= '0;
            irq <= 1'b0;
        end else begin
            lower_irq <= (lower_period_flag && lower_period_irq_enable)
                || (lower_event_flag && lower_event_irq_enable);
            upper_irq <= (upper_period_flag && upper_period_irq_enable)
                || (upper_event_flag && upper_event_irq_enable);
            compare_irq <= |(cmp_flags & cmp_mask);
            compare_dma_event <= cmp_hit;
            irq <= (lower_period_flag && lower_period_irq_enable)
                || (lower_event_flag && lower_event_irq_enable)
                || (upper_period_flag && upper_period_irq_enable)
                || (upper_event_flag && upper_event_irq_enable)
                || (|(cmp_flags & cmp_mask));
        end
    end

    // Checks on the logic above
    a_capture_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_UPPER_CAPTURE && !upper_capture_strobe |=> upper_capture_value == $past(pwdata))
        else $error("upper capture write lost");

    a_upper_event_set: assert property (@(posedge pclk) disable iff (!presetn)
        upper_capture_event |=> upper_event_flag)
        else $error("upper event flag not set");

    a_lower_event_hold: assert property (@(posedge pclk) disable iff (!presetn)
        lower_event_flag && !ics_clr[1] |=> lower_event_flag)
        else $error("lower event flag dropped without clear");

    a_upper_period_set: assert property (@(posedge pclk) disable iff (!presetn)
        upper_period_match && upper_timer_enable |=> upper_period_flag)
        else $error("upper period flag not set");

    a_lower_period_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !lower_period_flag && !(lower_period_match && lower_timer_enable) |=> !lower_period_flag)
        else $error("lower period flag set without cause");

    a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_INT_CTRL_STAT |=> upper_event_irq_enable == $past(pwdata[BIT_UPPER_EVENT_EN])
            && lower_period_irq_enable == $past(pwdata[BIT_LOWER_PERIOD_EN]))
        else $error("enable bits not written");

    a_reserved_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite && paddr == OFS_INT_CTRL_STAT |-> (prdata & ICS_RSV_MASK) == 32'h0)
        else $error("reserved bits read nonzero");

    a_cmp_gated: assert property (@(posedge pclk) disable iff (!presetn)
        !cmp_active [*2] |=> compare_dma_event == '0)
        else $error("compare event while feature off");

    a_cmp_dma: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_hit[0] |=> compare_dma_event[0] && cmp_flags[0])
        else $error("compare hit without DMA event or flag");

    a_lower_irq: assert property (@(posedge pclk) disable iff (!presetn)
        lower_irq |-> $past(lower_period_flag && lower_period_irq_enable)
            || $past(lower_event_flag && lower_event_irq_enable))
        else $error("lower interrupt without enabled flag");

    a_upper_irq: assert property (@(posedge pclk) disable iff (!presetn)
        upper_irq |-> $past(upper_period_flag && upper_period_irq_enable)
            || $past(upper_event_flag && upper_event_irq_enable))
        else $error("upper interrupt without enabled flag");

    a_upper_event_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_INT_CTRL_STAT && pwdata[BIT_UPPER_EVENT_FLAG] && !upper_capture_event |=> !upper_event_flag)
        else $error("upper event flag not cleared by write one");

    a_lower_event_set: assert property (@(posedge pclk) disable iff (!presetn)
        lower_capture_event |=> lower_event_flag)
        else $error("lower event flag not set");

    a_upper_period_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !upper_period_flag && !(upper_period_match && upper_timer_enable) |=> !upper_period_flag)
        else $error("upper period flag set without cause");

    a_lower_period_set: assert property (@(posedge pclk) disable iff (!presetn)
        lower_period_match && lower_timer_enable |=> lower_period_flag)
        else $error("lower period flag not set");

    a_lower_event_en: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_INT_CTRL_STAT |=> lower_event_irq_enable == $past(pwdata[BIT_LOWER_EVENT_EN]))
        else $error("lower event enable not written");

    a_upper_period_en: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_INT_CTRL_STAT |=> upper_period_irq_enable == $past(pwdata[BIT_UPPER_PERIOD_EN]))
        else $error("upper period enable not written");

    a_lower_period_en: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFS_INT_CTRL_STAT |=> lower_period_irq_enable == $past(pwdata[BIT_LOWER_PERIOD_EN]))
        else $error("lower period enable not written");

    a_cmp_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_hit[0] |=> !cmp_hit[0])
        else $error("held compare match gave a second event");

    a_cmp_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_clr[0] && !cmp_hit[0] |=> !cmp_flags[0])
        else $error("compare flag not cleared by write one");

    // Cover points for the main scenarios
    c_cmp_match: cover property (@(posedge pclk) disable iff (!presetn) cmp_active && cmp_hit != '0);
    c_period_irq: cover property (@(posedge pclk) disable iff (!presetn) upper_irq && lower_irq);
    c_set_clear: cover property (@(posedge pclk) disable iff (!presetn) ics_set[0] && ics_clr[0]);
    c_capture_load: cover property (@(posedge pclk) disable iff (!presetn) upper_capture_strobe);
    c_cmp_irq: cover property (@(posedge pclk) disable iff (!presetn) compare_irq && irq);
endmodule : timer_event_status_compare

// [timer_event_pkg.sv]
// Constants shared by the timer event, status and compare block.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
package timer_event_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_UPPER_CAPTURE = 8'h00;
    localparam logic [7:0] OFS_INT_CTRL_STAT = 8'h04;
    localparam logic [7:0] OFS_CMP_CTRL = 8'h08;
    localparam logic [7:0] OFS_CMP_STATUS = 8'h0C;
    localparam logic [7:0] OFS_CMP_MASK = 8'h10;
    localparam logic [7:0] OFS_CMP_BASE = 8'h20;
    localparam logic [7:0] OFS_CMP_LAST = 8'h3C;
    // Interrupt control and status field positions
    localparam int BIT_LOWER_PERIOD_EN = 0;
    localparam int BIT_LOWER_PERIOD_FLAG = 1;
    localparam int BIT_LOWER_EVENT_EN = 2;
    localparam int BIT_LOWER_EVENT_FLAG = 3;
    localparam int BIT_UPPER_PERIOD_EN = 16;
    localparam int BIT_UPPER_PERIOD_FLAG = 17;
    localparam int BIT_UPPER_EVENT_EN = 18;
    localparam int BIT_UPPER_EVENT_FLAG = 19;
    localparam logic [31:0] ICS_RSV_MASK = 32'hFFF0_FFF0;
    // Compare control field position
    localparam int BIT_CMP_FEATURE_EN = 0;
    // Reset value and compare channel count
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam int NUM_CMP = 8;
endpackage : timer_event_pkg

// [event_flag_bank.sv]
// Bank of sticky flags, set by hardware and cleared by writing ones.
// Assumes set and clear are single-cycle qualified pulses from the clock domain.
`timescale 1ns/1ns
module event_flag_bank #(
    parameter int W = 4
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic [W-1:0] set, // Hardware set pulses
    input wire logic [W-1:0] clr, // Software clear pulses
    output logic [W-1:0] q // Flag state
);
    // A set arriving with a clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= (q & ~clr) | set;
        end
    end
endmodule : event_flag_bank

// [compare_channel.sv]
// One compare channel: pulses one cycle after the counter first equals the compare value.
// Assumes the counter is synchronous to pclk; the channel only observes it.
`timescale 1ns/1ns
module compare_channel (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic active, // Compare feature in force
    input wire logic [31:0] count, // Lower counter half
    input wire logic [31:0] value, // Compare value
    output logic hit // One-cycle match pulse
);
    logic matched;

    // Edge of the match so a stalled counter gives one event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            matched <= 1'b0;
            hit <= 1'b0;
        end else begin
            matched <= active && (count == value);
            hit <= active && (count == value) && !matched;
        end
    end
endmodule : compare_channel

// [timer_event_status_compare_tb_top.sv]
// Self-checking testbench for the timer event status and compare block.
// Assumes timer_event_pkg and the design modules are compiled before it.
`timescale 1ns/1ns
module timer_event_status_compare_tb_top;
    import timer_event_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, unchained_mode, lower_timer_enable, upper_timer_enable;
    logic lower_period_match, upper_period_match, lower_capture_event, upper_capture_event, upper_capture_strobe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, lower_counter_half, upper_capture_data, rd;
    logic pready, pslverr, lower_irq, upper_irq, compare_irq, irq, er;
    logic [NUM_CMP-1:0] compare_dma_event;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int hits [NUM_CMP];

    timer_event_status_compare i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lower_counter_half(lower_counter_half), .unchained_mode(unchained_mode),
        .lower_timer_enable(lower_timer_enable), .upper_timer_enable(upper_timer_enable),
        .lower_period_match(lower_period_match), .upper_period_match(upper_period_match),
        .lower_capture_event(lower_capture_event), .upper_capture_event(upper_capture_event),
        .upper_capture_strobe(upper_capture_strobe), .upper_capture_data(upper_capture_data),
        .lower_irq(lower_irq), .upper_irq(upper_irq), .compare_irq(compare_irq),
        .compare_dma_event(compare_dma_event), .irq(irq));

    // Clock of 100 ns period
    initial forever #50 pclk = ~pclk;

    // Count DMA pulses per channel and cut a hang short
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        for (int i = 0; i < NUM_CMP; i++) if (compare_dma_event[i] === 1'b1) hits[i] = hits[i] + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task end_of_test();
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // One APB transfer; waits for pready, takes data at that edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        chk(32'(n), 32'h2, "access cycles");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, $sformatf("read %h", a));
    endtask : rchk

    // Irq outputs as {compare, upper, lower, combined}
    task irq_chk(input logic [3:0] exp);
        repeat (3) @(posedge pclk);
        chk({28'h0, compare_irq, upper_irq, lower_irq, irq}, {28'h0, exp}, "irq lines");
    endtask : irq_chk

    // Event pulses as {upper capture, lower capture, upper period, lower period}
    task pulse(input logic [3:0] p);
        @(posedge pclk);
        {upper_capture_event, lower_capture_event, upper_period_match, lower_period_match} <= p;
        @(posedge pclk);
        {upper_capture_event, lower_capture_event, upper_period_match, lower_period_match} <= 4'h0;
        repeat (3) @(posedge pclk);
    endtask : pulse

    // Counter walks past all compare values one step a cycle
    task sweep(input int exp);
        for (int i = 0; i < NUM_CMP; i++) hits[i] = 0;
        for (int v = 32'hF0; v < 32'h190; v++) begin
            @(posedge pclk);
            lower_counter_half <= 32'(v);
        end
        repeat (6) @(posedge pclk);
        for (int i = 0; i < NUM_CMP; i++) chk(32'(hits[i]), 32'(exp), $sformatf("dma hits ch%0d", i));
    endtask : sweep

    task t_reset_values();
        rchk(OFS_UPPER_CAPTURE, 32'h0);
        rchk(OFS_INT_CTRL_STAT, 32'h0);
        for (int i = 0; i < NUM_CMP; i++) rchk(OFS_CMP_BASE + 8'(4 * i), 32'h0);
        irq_chk(4'h0);
    endtask : t_reset_values

    task t_reserved_bits();
        apb(1'b1, OFS_INT_CTRL_STAT, 32'hFFFF_FFFF);
        rchk(OFS_INT_CTRL_STAT, 32'h0005_0005);
        apb(1'b1, 8'h05, 32'h0000_0000);
        chk({31'h0, er}, 32'h1, "misaligned refused");
        rchk(OFS_INT_CTRL_STAT, 32'h0005_0005);
        apb(1'b1, OFS_INT_CTRL_STAT, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000, "unmapped read");
    endtask : t_reserved_bits

    task t_period();
        apb(1'b1, OFS_INT_CTRL_STAT, 32'h0001_0001);
        pulse(4'h3);
        rchk(OFS_INT_CTRL_STAT, 32'h0001_0001);
        irq_chk(4'h0);
        {upper_timer_enable, lower_timer_enable} <= 2'b11;
        pulse(4'h1);
        rchk(OFS_INT_CTRL_STAT, 32'h0001_0003);
        irq_chk(4'b0011);
        pulse(4'h2);
        rchk(OFS_INT_CTRL_STAT, 32'h0003_0003);
        irq_chk(4'b0111);
        apb(1'b1, OFS_INT_CTRL_STAT, 32'h0001_0001);
        rchk(OFS_INT_CTRL_STAT, 32'h0003_0003);
        apb(1'b1, OFS_INT_CTRL_STAT, 32'h0003_0001);
        rchk(OFS_INT_CTRL_STAT, 32'h0001_0003);
        irq_chk(4'b0011);
        apb(1'b1, OFS_INT_CTRL_STAT, 32'h0000_0002);
        rchk(OFS_INT_CTRL_STAT, 32'h0);
        irq_chk(4'h0);
    endtask : t_period

    task t_capture_events();
        pulse(4'hC);
        rchk(OFS_INT_CTRL_STAT, 32'h0008_0008);
        irq_chk(4'h0);
        apb(1'b1, OFS_INT_CTRL_STAT, 32'h0004_0004);
        irq_chk(4'b0111);
        apb(1'b1, OFS_INT_CTRL_STAT, 32'h0000_0008);
        rchk(OFS_INT_CTRL_STAT, 32'h0008_0000);
        apb(1'b1, OFS_INT_CTRL_STAT, 32'h0008_0000);
        rchk(OFS_INT_CTRL_STAT, 32'h0);
    endtask : t_capture_events

    task t_capture_word();
        apb(1'b1, OFS_UPPER_CAPTURE, 32'hA5A5_5A5A);
        rchk(OFS_UPPER_CAPTURE, 32'hA5A5_5A5A);
        upper_capture_data <= 32'h1234_5678;
        upper_capture_strobe <= 1'b1;
        @(posedge pclk);
        upper_capture_strobe <= 1'b0;
        rchk(OFS_UPPER_CAPTURE, 32'h1234_5678);
    endtask : t_capture_word

    task t_compare();
        for (int i = 0; i < NUM_CMP; i++) apb(1'b1, OFS_CMP_BASE + 8'(4 * i), 32'h100 + 32'(16 * i));
        rchk(OFS_CMP_LAST, 32'h170);
        apb(1'b1, OFS_CMP_MASK, 32'hFF);
        unchained_mode <= 1'b1;
        sweep(0);
        apb(1'b1, OFS_CMP_CTRL, 32'h1);
        unchained_mode <= 1'b0;
        sweep(0);
        unchained_mode <= 1'b1;
        sweep(1);
        rchk(OFS_CMP_STATUS, 32'hFF);
        irq_chk(4'b1001);
        apb(1'b1, OFS_CMP_MASK, 32'h0);
        irq_chk(4'h0);
        apb(1'b1, OFS_CMP_STATUS, 32'hFF);
        rchk(OFS_CMP_STATUS, 32'h0);
        irq_chk(4'h0);
    endtask : t_compare

    task t_mid_reset();
        apb(1'b1, OFS_INT_CTRL_STAT, 32'h0005_0005);
        pulse(4'hF);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(OFS_INT_CTRL_STAT, 32'h0);
        rchk(OFS_UPPER_CAPTURE, 32'h0);
        irq_chk(4'h0);
    endtask : t_mid_reset

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {unchained_mode, lower_timer_enable, upper_timer_enable, upper_capture_strobe} = '0;
        {lower_period_match, upper_period_match, lower_capture_event, upper_capture_event} = '0;
        lower_counter_half = 32'h0;
        upper_capture_data = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_reserved_bits();
        t_period();
        t_capture_events();
        t_capture_word();
        t_compare();
        t_mid_reset();
        end_of_test();
    end
endmodule : timer_event_status_compare_tb_top
